// ===== rtl/hisc_pkg.sv
// Package for the host interface sequencer control block.
// Holds register offsets, field positions, reset values and sizes.
// Assumes an 8-bit register port with byte-wide registers.
package hisc_pkg;

  // ----------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------
  localparam logic [7:0] HISC_OFS_CONFIG = 8'h95; // Host interface configuration one.
  localparam logic [7:0] HISC_OFS_IRQ_STAT = 8'h98; // Sticky event flags, write one to clear.
  localparam logic [7:0] HISC_OFS_IRQ_MASK = 8'h99; // Interrupt enables, same layout.
  localparam logic [7:0] HISC_OFS_EXT_LOW = 8'h9a; // Low three bits of the timing extension.
  localparam logic [7:0] HISC_OFS_SEQ_STAT = 8'h9b; // Sequencer and FIFO state, read only.
  localparam logic [7:0] HISC_OFS_XFER_LO = 8'h9c; // Transfer counter low byte, read only.
  localparam logic [7:0] HISC_OFS_PKT_LO = 8'h9d; // Packet size store low byte, read only.

  // ----------------------------------------------------------------
  // Configuration register fields.
  // ----------------------------------------------------------------
  localparam int HISC_CFG_DMA_SUSPEND = 7;
  localparam int HISC_CFG_STAT_HIPRI_OFF = 6;
  localparam int HISC_CFG_UDMA_KEEP = 5;
  localparam int HISC_CFG_FLUSH_FIFO = 4;
  localparam int HISC_CFG_UNMASK_DTEI = 2;
  localparam int HISC_CFG_CLEAR_CNT = 1;
  localparam int HISC_CFG_EXT_BIT3 = 0;
  localparam logic [7:0] HISC_CFG_STORED_MASK = 8'he5; // Bits that hold a value.
  localparam logic [7:0] HISC_CFG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Status register fields (interrupt status and mask share them).
  // ----------------------------------------------------------------
  localparam int HISC_ST_SUSPEND = 0;
  localparam int HISC_ST_XFER_END = 1;
  localparam int HISC_ST_DTEI = 6;
  localparam logic [7:0] HISC_ST_USED_MASK = 8'h43;
  localparam logic [7:0] HISC_IRQ_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Sizes and timing.
  // ----------------------------------------------------------------
  localparam int HISC_CMD_DEPTH = 12; // Command FIFO bytes.
  localparam logic [3:0] HISC_CMD_LAST = 4'hb; // Index of the last command byte.
  localparam logic [3:0] HISC_PTR_RESET = 4'h0;
  localparam logic [15:0] HISC_CNT_RESET = 16'h0000;
  localparam logic [2:0] HISC_EXT_LOW_RESET = 3'h0;
  localparam logic [7:0] HISC_UDMA_BASE_LIMIT = 8'h04; // Base length of an ultra DMA timing limit.

  // ----------------------------------------------------------------
  // Sequencer states.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HISC_SEQ_IDLE,
    HISC_SEQ_RUN,
    HISC_SEQ_SUSPEND
  } hisc_seq_state_t;

endpackage : hisc_pkg

// ===== rtl/hisc_ext_timer.sv
// Timing limit stretcher for the ultra DMA engine.
// Assumes a start pulse from the engine and a stable extension field.
`timescale 1ns/1ps
`default_nettype none
module hisc_ext_timer
  import hisc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Control.
  input wire logic start,
  input wire logic [3:0] ext_cycles,
  // Result.
  output logic busy,
  output logic done
);

  // ----------------------------------------------------------------
  // Down counter.
  // ----------------------------------------------------------------
  logic [8:0] cnt_ff; // Cycles left in the current limit.
  logic [8:0] nxt_cnt;
  logic done_ff; // One-cycle pulse at the end of a limit.
  logic nxt_done;

  // The extension is added to the base, so a larger field only lengthens the limit.
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_cnt = {1'b0, HISC_UDMA_BASE_LIMIT} + {5'h00, ext_cycles};
    end else if (cnt_ff != 9'h000) begin
      nxt_cnt = cnt_ff - 9'h001;
      nxt_done = (cnt_ff == 9'h001);
    end
  end

  // Register stage.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_ff <= 9'h000;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign busy = (cnt_ff != 9'h000);
  assign done = done_ff;

endmodule : hisc_ext_timer
`default_nettype wire

// ===== rtl/hisc_top.sv
// Host interface sequencer control: configuration register one and the logic it steers.
// Assumes a byte register port from the local microcontroller and event pulses
// from the host port, the auto sequencer datapath and the ultra DMA engine.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hisc_top
  import hisc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Host command bytes.
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_wdata,
  input wire logic [3:0] cmd_rd_idx,
  output logic [7:0] cmd_rdata,
  output logic cmd_full,
  // Auto sequencer events.
  input wire logic autodrq_en,
  input wire logic drq_want,
  input wire logic dtei_evt,
  input wire logic xfer_end,
  input wire logic xfer_word,
  input wire logic pkt_load,
  input wire logic [15:0] pkt_size,
  // Ultra DMA engine.
  input wire logic udma_limit_start,
  output logic udma_limit_busy,
  output logic udma_limit_done,
  output logic udma_en_clr,
  // ATA status and interrupts.
  output logic ata_bsy,
  output logic ata_drq,
  output logic dtei_irq,
  output logic seq_suspended,
  output logic dma_suspend_en,
  output logic stat_hipri_off,
  output logic irq
);

  // ----------------------------------------------------------------
  // Register port decode.
  // ----------------------------------------------------------------
  logic wr_cfg; // Write to the configuration register.
  logic wr_stat; // Write one to clear on the status register.
  logic wr_mask; // Write to the mask register.
  logic wr_ext; // Write to the low extension bits.
  assign wr_cfg = reg_wr && (reg_addr == HISC_OFS_CONFIG);
  assign wr_stat = reg_wr && (reg_addr == HISC_OFS_IRQ_STAT);
  assign wr_mask = reg_wr && (reg_addr == HISC_OFS_IRQ_MASK);
  assign wr_ext = reg_wr && (reg_addr == HISC_OFS_EXT_LOW);

  // Strobe bits come from the write itself, never from stored state.
  logic flush_stb; // Pointer flush request.
  logic clear_stb; // Counter clear request.
  assign flush_stb = wr_cfg && reg_wdata[HISC_CFG_FLUSH_FIFO];
  assign clear_stb = wr_cfg && reg_wdata[HISC_CFG_CLEAR_CNT];

  // ----------------------------------------------------------------
  // Configuration, mask and extension registers.
  // ----------------------------------------------------------------
  logic [7:0] cfg_ff; // Stored configuration bits; strobe positions stay zero.
  logic [7:0] nxt_cfg;
  logic [7:0] mask_ff; // Interrupt enables.
  logic [7:0] nxt_mask;
  logic [2:0] ext_low_ff; // Timing extension bits two to zero.
  logic [2:0] nxt_ext_low;
  logic [3:0] ext_field; // Full four-bit timing extension.

  // Flush and clear are not kept, so they read back as zero.
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_mask = mask_ff;
    nxt_ext_low = ext_low_ff;
    if (wr_cfg) begin
      nxt_cfg = reg_wdata & HISC_CFG_STORED_MASK;
    end
    if (wr_mask) begin
      nxt_mask = reg_wdata & HISC_ST_USED_MASK;
    end
    if (wr_ext) begin
      nxt_ext_low = reg_wdata[2:0];
    end
  end

  // Register stage.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_ff <= HISC_CFG_RESET;
      mask_ff <= HISC_IRQ_RESET;
      ext_low_ff <= HISC_EXT_LOW_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
      mask_ff <= nxt_mask;
      ext_low_ff <= nxt_ext_low;
    end
  end

  assign ext_field = {cfg_ff[HISC_CFG_EXT_BIT3], ext_low_ff};
  assign dma_suspend_en = cfg_ff[HISC_CFG_DMA_SUSPEND];
  assign stat_hipri_off = cfg_ff[HISC_CFG_STAT_HIPRI_OFF];

  // ----------------------------------------------------------------
  // Ultra DMA enable clear and timing extension.
  // ----------------------------------------------------------------
  logic udma_clr_ff; // One-cycle clear pulse toward the transfer control register.
  logic nxt_udma_clr;

  // The transfer control register lives elsewhere, so this block only issues the clear.
  always_comb begin
    nxt_udma_clr = xfer_end && !cfg_ff[HISC_CFG_UDMA_KEEP];
  end

  // Register stage.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      udma_clr_ff <= 1'b0;
    end else begin
      udma_clr_ff <= nxt_udma_clr;
    end
  end

  assign udma_en_clr = udma_clr_ff;

  // Stretches engine limits by the extension field.
  hisc_ext_timer u_ext_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(udma_limit_start),
    .ext_cycles(ext_field),
    .busy(udma_limit_busy),
    .done(udma_limit_done)
  );

  // ----------------------------------------------------------------
  // Twelve-byte command FIFO.
  // ----------------------------------------------------------------
  logic [7:0] cmd_mem [HISC_CMD_DEPTH]; // Command bytes.
  logic [3:0] cmd_ptr_ff; // Next byte to load; twelve means full.
  logic [3:0] nxt_cmd_ptr;
  logic [7:0] cmd_rdata_ff; // Registered read of the selected byte.
  logic [7:0] nxt_cmd_rdata;
  logic cmd_load; // A byte is taken this cycle.

  // Bytes past the twelfth are dropped; firmware flushes to start over.
  assign cmd_load = cmd_wr && (cmd_ptr_ff <= HISC_CMD_LAST) && !flush_stb;

  // Flush beats a load in the same cycle so the next command starts clean.
  always_comb begin
    nxt_cmd_ptr = cmd_ptr_ff;
    if (flush_stb) begin
      nxt_cmd_ptr = HISC_PTR_RESET;
    end else if (cmd_load) begin
      nxt_cmd_ptr = cmd_ptr_ff + 4'h1;
    end
    nxt_cmd_rdata = 8'h00;
    if (cmd_rd_idx <= HISC_CMD_LAST) begin
      nxt_cmd_rdata = cmd_mem[cmd_rd_idx];
    end
  end

  // Register stage; the byte array needs no reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_ptr_ff <= HISC_PTR_RESET;
      cmd_rdata_ff <= 8'h00;
    end else begin
      cmd_ptr_ff <= nxt_cmd_ptr;
      cmd_rdata_ff <= nxt_cmd_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (cmd_load) begin
      cmd_mem[cmd_ptr_ff] <= cmd_wdata;
    end
  end

  assign cmd_rdata = cmd_rdata_ff;
  assign cmd_full = (cmd_ptr_ff > HISC_CMD_LAST);

  // ----------------------------------------------------------------
  // Transfer counter and packet size store.
  // ----------------------------------------------------------------
  logic [15:0] xfer_cnt_ff; // Words moved by the sequencer.
  logic [15:0] nxt_xfer_cnt;
  logic [15:0] pkt_ff; // Packet size store.
  logic [15:0] nxt_pkt;

  // The clear wins for its one cycle only; counting resumes at once after it.
  always_comb begin
    nxt_xfer_cnt = xfer_cnt_ff;
    nxt_pkt = pkt_ff;
    if (clear_stb) begin
      nxt_xfer_cnt = HISC_CNT_RESET;
      nxt_pkt = HISC_CNT_RESET;
    end else begin
      if (xfer_word) begin
        nxt_xfer_cnt = xfer_cnt_ff + 16'h0001;
      end
      if (pkt_load) begin
        nxt_pkt = pkt_size;
      end
    end
  end

  // Register stage.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      xfer_cnt_ff <= HISC_CNT_RESET;
      pkt_ff <= HISC_CNT_RESET;
    end else begin
      xfer_cnt_ff <= nxt_xfer_cnt;
      pkt_ff <= nxt_pkt;
    end
  end

  // ----------------------------------------------------------------
  // Auto data request sequencer.
  // ----------------------------------------------------------------
  hisc_seq_state_t state_ff; // Sequencer state.
  hisc_seq_state_t nxt_state;
  logic bsy_ff; // ATA busy flag.
  logic nxt_bsy;
  logic drq_ff; // ATA data request flag.
  logic nxt_drq;
  logic dtei_irq_ff; // Unmasked transfer end interrupt to the microcontroller.
  logic nxt_dtei_irq;
  logic susp_evt; // One-cycle pulse when a suspend begins.
  logic unmask; // Unmask bit as stored.
  assign unmask = cfg_ff[HISC_CFG_UNMASK_DTEI];

  // Masked transfer end events leave the sequencer running; only the unmask bit lets them stop the run.
  always_comb begin
    nxt_state = state_ff;
    nxt_bsy = bsy_ff;
    nxt_drq = drq_ff;
    nxt_dtei_irq = dtei_irq_ff;
    susp_evt = 1'b0;
    case (state_ff)
      HISC_SEQ_IDLE: begin
        nxt_bsy = 1'b0;
        nxt_drq = 1'b0;
        if (autodrq_en) begin
          nxt_state = HISC_SEQ_RUN;
        end
      end
      HISC_SEQ_RUN: begin
        nxt_bsy = !drq_want;
        nxt_drq = drq_want;
        if (dtei_evt && unmask) begin
          nxt_state = HISC_SEQ_SUSPEND;
          nxt_bsy = 1'b1;
          nxt_drq = 1'b0;
          nxt_dtei_irq = 1'b1;
          susp_evt = 1'b1;
        end else if (!autodrq_en) begin
          nxt_state = HISC_SEQ_IDLE;
        end
      end
      HISC_SEQ_SUSPEND: begin
        nxt_bsy = 1'b1;
        nxt_drq = 1'b0;
        if (!unmask) begin
          nxt_state = HISC_SEQ_RUN;
          nxt_dtei_irq = 1'b0;
        end
      end
      default: begin
        nxt_state = HISC_SEQ_IDLE;
      end
    endcase
  end

  // Register stage.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= HISC_SEQ_IDLE;
      bsy_ff <= 1'b0;
      drq_ff <= 1'b0;
      dtei_irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bsy_ff <= nxt_bsy;
      drq_ff <= nxt_drq;
      dtei_irq_ff <= nxt_dtei_irq;
    end
  end

  assign ata_bsy = bsy_ff;
  assign ata_drq = drq_ff;
  assign dtei_irq = dtei_irq_ff;
  assign seq_suspended = (state_ff == HISC_SEQ_SUSPEND);

  // ----------------------------------------------------------------
  // Sticky status and interrupt.
  // ----------------------------------------------------------------
  logic [7:0] stat_ff; // Sticky event flags.
  logic [7:0] nxt_stat;
  logic [7:0] stat_set; // Events of this cycle.

  // A set in the clearing cycle survives, so no event is lost.
  always_comb begin
    stat_set = 8'h00;
    stat_set[HISC_ST_DTEI] = dtei_evt;
    stat_set[HISC_ST_XFER_END] = xfer_end;
    stat_set[HISC_ST_SUSPEND] = susp_evt;
    nxt_stat = stat_ff;
    if (wr_stat) begin
      nxt_stat = stat_ff & ~reg_wdata;
    end
    nxt_stat = nxt_stat | stat_set;
  end

  // Register stage.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stat_ff <= HISC_IRQ_RESET;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign irq = |(stat_ff & mask_ff);

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe.
  // ----------------------------------------------------------------
  logic [7:0] rdata_ff; // Registered read data.
  logic [7:0] nxt_rdata;

  // Unmapped offsets and idle cycles read as zero.
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        HISC_OFS_CONFIG: nxt_rdata = cfg_ff;
        HISC_OFS_IRQ_STAT: nxt_rdata = stat_ff;
        HISC_OFS_IRQ_MASK: nxt_rdata = mask_ff;
        HISC_OFS_EXT_LOW: nxt_rdata = {5'h00, ext_low_ff};
        HISC_OFS_SEQ_STAT: nxt_rdata = {seq_suspended, bsy_ff, drq_ff, cmd_full, cmd_ptr_ff};
        HISC_OFS_XFER_LO: nxt_rdata = xfer_cnt_ff[7:0];
        HISC_OFS_PKT_LO: nxt_rdata = pkt_ff[7:0];
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Register stage.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule : hisc_top
`default_nettype wire

// ===== bench/hisc_host_model.sv
// Far side model: the host controller that is ready or not and moves words.
// Assumes one core clock and a synchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module hisc_host_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Bench control.
  input wire logic go,
  // Device side.
  input wire logic ata_drq,
  output logic drq_want,
  output logic xfer_word,
  output logic [15:0] word_cnt
);
  logic [7:0] lfsr_ff; // Readiness pattern, so the device sees both levels.
  logic [7:0] nxt_lfsr; // Next pattern.
  logic nxt_word; // Next word strobe.
  logic [15:0] nxt_cnt; // Words handed over so far.
  // A word moves only while the device shows DRQ, at most every other cycle.
  always_comb begin
    nxt_lfsr = {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
    nxt_word = go && ata_drq && !xfer_word;
    nxt_cnt = word_cnt + {15'h0000, nxt_word};
  end
  // Registers only.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lfsr_ff <= 8'h5a;
      xfer_word <= 1'b0;
      word_cnt <= 16'h0000;
    end else begin
      lfsr_ff <= nxt_lfsr;
      xfer_word <= nxt_word;
      word_cnt <= nxt_cnt;
    end
  end
  assign drq_want = lfsr_ff[0];
endmodule : hisc_host_model
`default_nettype wire

// ===== bench/hisc_checker.sv
// Concurrent checks on the ports of the sequencer control top.
// Assumes the config register is only changed by port writes.
`timescale 1ns/1ps
`default_nettype none
module hisc_checker
  import hisc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Observed ports.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cmd_full,
  input wire logic autodrq_en,
  input wire logic dtei_evt,
  input wire logic xfer_end,
  input wire logic udma_en_clr,
  input wire logic ata_bsy,
  input wire logic ata_drq,
  input wire logic dtei_irq,
  input wire logic seq_suspended
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Shadow of the stored config bits.
  // ----------------------------------------------------------------
  logic [7:0] cfg_ff; // Strobe bits never land here.
  logic [7:0] nxt_cfg; // Next shadow value.
  always_comb begin
    nxt_cfg = cfg_ff;
    if (reg_wr && reg_addr == HISC_OFS_CONFIG) begin
      nxt_cfg = reg_wdata & HISC_CFG_STORED_MASK;
    end
  end
  // Registers only.
  always_ff @(posedge core_clk) begin
    cfg_ff <= rst ? HISC_CFG_RESET : nxt_cfg;
  end
  sequence s_cfg_wr;
    reg_wr && reg_addr == HISC_OFS_CONFIG;
  endsequence
  sequence s_susp;
    ata_bsy && !ata_drq && dtei_irq && seq_suspended;
  endsequence
  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  udma_clr_a: assert property (xfer_end && !cfg_ff[5] |=> udma_en_clr)
    else $error("ultra DMA enable not cleared at transfer end");
  udma_keep_a: assert property (!(xfer_end && !cfg_ff[5]) |=> !udma_en_clr)
    else $error("ultra DMA enable cleared without cause");
  flush_ptr_a: assert property (s_cfg_wr ##0 reg_wdata[4] |=> !cmd_full)
    else $error("command pointer not zeroed by flush");
  susp_enter_a: assert property (dtei_evt && cfg_ff[2] && autodrq_en && $past(autodrq_en, 2)
    && (ata_bsy != ata_drq) && !seq_suspended |=> s_susp)
    else $error("unmasked transfer end did not suspend");
  dtei_mask_a: assert property (dtei_evt && !cfg_ff[2] && !seq_suspended |=> !seq_suspended)
    else $error("masked transfer end suspended the sequencer");
  susp_hold_a: assert property (seq_suspended && cfg_ff[2] |=> s_susp)
    else $error("suspend left while unmask still set");
  resume_a: assert property (seq_suspended && !cfg_ff[2] |=> !seq_suspended && !dtei_irq)
    else $error("sequencer did not resume");
  cfg_read_a: assert property (reg_rd && reg_addr == HISC_OFS_CONFIG |=> reg_rdata == cfg_ff)
    else $error("config read back wrong");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule : hisc_checker
bind hisc_top hisc_checker u_chk (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .cmd_full, .autodrq_en, .dtei_evt, .xfer_end, .udma_en_clr, .ata_bsy, .ata_drq, .dtei_irq,
  .seq_suspended);
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the sequencer control top with a host model.
// Assumes the package offsets and a 100 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hisc_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cmd_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cmd_wdata = 8'h00, d, b [13];
  logic [3:0] cmd_rd_idx = 4'h0;
  logic autodrq_en = 1'b0, dtei_evt = 1'b0, xfer_end = 1'b0, pkt_load = 1'b0;
  logic udma_limit_start = 1'b0, go = 1'b0, drq_want, xfer_word;
  logic [15:0] pkt_size = 16'h0000, word_cnt, snap;
  logic [7:0] reg_rdata, cmd_rdata;
  logic cmd_full, udma_limit_busy, udma_limit_done, udma_en_clr, ata_bsy, ata_drq;
  logic dtei_irq, seq_suspended, dma_suspend_en, stat_hipri_off, irq;
  int bad_count = 0, checks = 0, n;
  always #5 core_clk = ~core_clk;
  hisc_top dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_wr,
    .cmd_wdata, .cmd_rd_idx, .cmd_rdata, .cmd_full, .autodrq_en, .drq_want, .dtei_evt, .xfer_end,
    .xfer_word, .pkt_load, .pkt_size, .udma_limit_start, .udma_limit_busy, .udma_limit_done,
    .udma_en_clr, .ata_bsy, .ata_drq, .dtei_irq, .seq_suspended, .dma_suspend_en,
    .stat_hipri_off, .irq);
  hisc_host_model host (.core_clk, .rst, .go, .ata_drq, .drq_want, .xfer_word, .word_cnt);
  // ----------------------------------------------------------------
  // Bus cycles, comparison and verdict.
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic wrap_up();
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // Watchdog: the tests need a few hundred cycles at most.
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(81323));
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd(HISC_OFS_CONFIG, d); chk(d, HISC_CFG_RESET);
    wr(8'h00, 8'($urandom)); rd(8'h00, d); chk(d, 8'h00);
    // Random config values: strobe bits must read back as zero.
    for (int i = 0; i < 4; i++) begin
      n = $urandom;
      wr(HISC_OFS_CONFIG, n[7:0]); rd(HISC_OFS_CONFIG, d);
      chk(d, n[7:0] & 8'he5);
      chk({dma_suspend_en, stat_hipri_off}, n[7:6]);
    end
    // Command FIFO: overfill, read back, flush, partial load.
    wr(HISC_OFS_CONFIG, 8'h10);
    for (int i = 0; i < 13; i++) begin
      b[i] = 8'($urandom);
      @(posedge core_clk);
      cmd_wr <= 1'b1;
      cmd_wdata <= b[i];
    end
    @(posedge core_clk);
    cmd_wr <= 1'b0;
    #1 chk(cmd_full, 1'b1);
    for (int i = 0; i < 13; i++) begin
      @(posedge core_clk);
      cmd_rd_idx <= i[3:0];
      @(posedge core_clk);
      #1 chk(cmd_rdata, (i < 12) ? b[i] : 8'h00);
    end
    wr(HISC_OFS_CONFIG, 8'h10); rd(HISC_OFS_SEQ_STAT, d); chk(d & 8'h1f, 8'h00);
    repeat (3) begin
      @(posedge core_clk);
      cmd_wr <= 1'b1;
    end
    @(posedge core_clk);
    cmd_wr <= 1'b0;
    wr(HISC_OFS_CONFIG, 8'h00); rd(HISC_OFS_SEQ_STAT, d); chk(d & 8'h1f, 8'h03);
    // Transfer end: clears the DMA enable only with the keep bit low; interrupt path.
    wr(HISC_OFS_IRQ_STAT, 8'hff);
    for (int k = 0; k < 2; k++) begin
      wr(HISC_OFS_CONFIG, k ? 8'h20 : 8'h00);
      @(posedge core_clk);
      xfer_end <= 1'b1;
      @(posedge core_clk);
      xfer_end <= 1'b0;
      #1 chk(udma_en_clr, !k);
    end
    rd(HISC_OFS_IRQ_STAT, d); chk(d & HISC_ST_USED_MASK, 8'h02); chk(irq, 1'b0);
    wr(HISC_OFS_IRQ_MASK, 8'h02); #1 chk(irq, 1'b1);
    wr(HISC_OFS_IRQ_STAT, 8'h02); #1 chk(irq, 1'b0);
    wr(HISC_OFS_IRQ_MASK, 8'h00);
    // Sequencer running with the host moving words; counters and clear.
    autodrq_en <= 1'b1;
    wr(HISC_OFS_CONFIG, 8'h02);
    @(posedge core_clk);
    pkt_load <= 1'b1;
    pkt_size <= 16'($urandom);
    @(posedge core_clk);
    pkt_load <= 1'b0;
    go <= 1'b1;
    repeat (40) @(posedge core_clk);
    go <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(HISC_OFS_XFER_LO, d); chk(d, word_cnt[7:0]);
    rd(HISC_OFS_PKT_LO, d); chk(d, pkt_size[7:0]);
    wr(HISC_OFS_CONFIG, 8'h00); rd(HISC_OFS_XFER_LO, d); chk(d, word_cnt[7:0]);
    wr(HISC_OFS_CONFIG, 8'h02); snap = word_cnt;
    rd(HISC_OFS_XFER_LO, d); chk(d, 8'h00);
    rd(HISC_OFS_PKT_LO, d); chk(d, 8'h00);
    go <= 1'b1;
    repeat (30) @(posedge core_clk);
    go <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(HISC_OFS_XFER_LO, d); chk(d, 8'(word_cnt[7:0] - snap[7:0]));
    // Transfer end events with unmask clear, then set; resume after reconfiguring.
    for (int k = 0; k < 2; k++) begin
      wr(HISC_OFS_IRQ_STAT, 8'hff);
      wr(HISC_OFS_CONFIG, k ? 8'h04 : 8'h00);
      repeat (3) @(posedge core_clk);
      dtei_evt <= 1'b1;
      @(posedge core_clk);
      dtei_evt <= 1'b0;
      #1 chk({seq_suspended, ata_bsy, ata_drq, dtei_irq}, k ? 4'hd : {1'b0, ata_bsy, ata_drq, 1'b0});
      rd(HISC_OFS_IRQ_STAT, d); chk(d & HISC_ST_USED_MASK, k ? 8'h41 : 8'h40);
    end
    wr(HISC_OFS_EXT_LOW, 8'h01);
    #1 chk(seq_suspended, 1'b1);
    wr(HISC_OFS_CONFIG, 8'h00);
    @(posedge core_clk);
    autodrq_en <= 1'b0;
    #1 chk({seq_suspended, dtei_irq}, 2'b00);
    // Timing limits stretched by the four-bit extension; 0001 is the slow-clock setting.
    foreach (b[i]) begin
      if (i > 3) break;
      n = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 9 : 15;
      wr(HISC_OFS_EXT_LOW, {5'h00, n[2:0]}); wr(HISC_OFS_CONFIG, {7'h00, n[3]});
      @(posedge core_clk);
      udma_limit_start <= 1'b1;
      @(posedge core_clk);
      udma_limit_start <= 1'b0;
      d = 8'h00;
      for (int c = 0; c < 40; c++) begin
        #1 if (udma_limit_busy === 1'b1) d++;
        if (udma_limit_done === 1'b1) break;
        @(posedge core_clk);
      end
      chk(udma_limit_done, 1'b1);
      chk(d, 8'd4 + n[7:0]);
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
